/* irqmask_pkg.sv */
// Package holding the register map, field layout and state record of the stage interrupt masks.
package irqmask_pkg;

   localparam int STAGES     = 12;
   localparam int DONE_W     = 13;
   localparam int IDX_W      = 10;
   localparam int ADDR_W     = 12;

   // Register indexes; the byte address on the bus is four times the index.
   localparam logic [IDX_W-1:0] IDX_HI_MASK   = 10'h006;
   localparam logic [IDX_W-1:0] IDX_DONE_MASK = 10'h007;
   localparam logic [IDX_W-1:0] IDX_HI_STAT   = 10'h009;
   localparam logic [IDX_W-1:0] IDX_DONE_STAT = 10'h00A;
   localparam logic [IDX_W-1:0] IDX_GPIO_CFG  = 10'h00C;

   localparam int GPIO_EVENT_BIT = 12;
   localparam int TRIG_LSB       = 14;

   localparam logic [STAGES-1:0] HI_MASK_RESET   = 12'h000;
   localparam logic [DONE_W-1:0] DONE_MASK_RESET = 13'h0000;
   localparam logic [STAGES-1:0] HI_STAT_RESET   = 12'h000;
   localparam logic [DONE_W-1:0] DONE_STAT_RESET = 13'h0000;

   typedef enum logic [1:0] {
      TRIG_LOW_LEVEL  = 2'h0,
      TRIG_RISE_EDGE  = 2'h1,
      TRIG_FALL_EDGE  = 2'h2,
      TRIG_HIGH_LEVEL = 2'h3
   } trig_t;

   localparam trig_t TRIG_RESET = TRIG_LOW_LEVEL;

   typedef enum logic {
      PH_ACCESS,
      PH_ANSWER
   } phase_t;

   typedef struct packed {
      phase_t            phase;
      logic [STAGES-1:0] hi_mask;
      logic [DONE_W-1:0] done_mask;
      logic [STAGES-1:0] hi_stat;
      logic [DONE_W-1:0] done_stat;
      trig_t             trig;
      logic              gpio_prev;
      logic [31:0]       rdata;
      logic              slverr;
      logic              int_n;
   } state_t;

endpackage : irqmask_pkg

/* stage_irq_masks.sv */
// Stage interrupt mask block: enable masks, sticky event status and the interrupt output.
//
// The APB register port was decided locally.
`timescale 1ns/1ps

module stage_irq_masks (
   input  wire logic                                CLK,
   input  wire logic                                RESET_N,
   input  wire logic                                CE,
   input  wire logic                                PSEL,
   input  wire logic                                PENABLE,
   input  wire logic                                PWRITE,
   input  wire logic [irqmask_pkg::ADDR_W-1:0]      PADDR,
   input  wire logic [31:0]                         PWDATA,
   input  wire logic [3:0]                          PSTRB,
   output logic      [31:0]                         PRDATA,
   output logic                                     PREADY,
   output logic                                     PSLVERR,
   input  wire logic [irqmask_pkg::STAGES-1:0]      STAGE_HIGH_EXCEEDED,
   input  wire logic [irqmask_pkg::STAGES-1:0]      STAGE_DONE,
   input  wire logic                                GPIO_IN,
   output logic                                     INT_N
);

   irqmask_pkg::state_t st_q;
   irqmask_pkg::state_t st_d;

   logic                               req;
   logic [irqmask_pkg::IDX_W-1:0]      idx;
   logic                               mapped;
   logic                               finish;
   logic [irqmask_pkg::STAGES-1:0]     hi_clear;
   logic [irqmask_pkg::DONE_W-1:0]     done_clear;
   logic                               gpio_event;

   function automatic logic [irqmask_pkg::IDX_W-1:0] reg_index(
      input logic [irqmask_pkg::ADDR_W-1:0] addr
   );
      reg_index = addr[irqmask_pkg::ADDR_W-1:2];
   endfunction : reg_index

   function automatic logic is_mapped(input logic [irqmask_pkg::IDX_W-1:0] i);
      is_mapped = (i == irqmask_pkg::IDX_HI_MASK)   || (i == irqmask_pkg::IDX_DONE_MASK) ||
                  (i == irqmask_pkg::IDX_HI_STAT)   || (i == irqmask_pkg::IDX_DONE_STAT) ||
                  (i == irqmask_pkg::IDX_GPIO_CFG);
   endfunction : is_mapped

   // Merges the two low byte lanes of a write into a 16-bit register image.
   function automatic logic [15:0] merge_lanes(
      input logic [15:0] old,
      input logic [31:0] wdata,
      input logic [3:0]  strb
   );
      merge_lanes[7:0]  = strb[0] ? wdata[7:0]  : old[7:0];
      merge_lanes[15:8] = strb[1] ? wdata[15:8] : old[15:8];
   endfunction : merge_lanes

   function automatic logic [31:0] read_mux(
      input irqmask_pkg::state_t    s,
      input logic [irqmask_pkg::IDX_W-1:0] i
   );
      read_mux = 32'h0000_0000;
      case (i)
         irqmask_pkg::IDX_HI_MASK:   read_mux[irqmask_pkg::STAGES-1:0] = s.hi_mask;
         irqmask_pkg::IDX_DONE_MASK: read_mux[irqmask_pkg::DONE_W-1:0] = s.done_mask;
         irqmask_pkg::IDX_HI_STAT:   read_mux[irqmask_pkg::STAGES-1:0] = s.hi_stat;
         irqmask_pkg::IDX_DONE_STAT: read_mux[irqmask_pkg::DONE_W-1:0] = s.done_stat;
         irqmask_pkg::IDX_GPIO_CFG:  read_mux[irqmask_pkg::TRIG_LSB+:2] = s.trig;
         default:                    read_mux = 32'h0000_0000;
      endcase
   endfunction : read_mux

   assign PRDATA  = st_q.rdata;
   assign PREADY  = (st_q.phase == irqmask_pkg::PH_ANSWER);
   assign PSLVERR = PREADY && st_q.slverr;
   assign INT_N   = st_q.int_n;

   always_comb begin
      logic [15:0] img;
      img        = 16'h0000;
      st_d       = st_q;
      req        = PSEL && PENABLE;
      idx        = reg_index(PADDR);
      mapped     = is_mapped(idx);
      finish     = (st_q.phase == irqmask_pkg::PH_ANSWER) && req;
      hi_clear   = '0;
      done_clear = '0;
      gpio_event = 1'b0;

      // One wait state lets read data come from a flip-flop; the value is taken then.
      case (st_q.phase)
         irqmask_pkg::PH_ACCESS: begin
            if (req) begin
               st_d.phase  = irqmask_pkg::PH_ANSWER;
               st_d.rdata  = PWRITE ? 32'h0000_0000 : read_mux(st_q, idx);
               st_d.slverr = !mapped;
            end
         end
         irqmask_pkg::PH_ANSWER: begin
            st_d.phase  = irqmask_pkg::PH_ACCESS;
            st_d.slverr = 1'b0;
         end
         default: begin
            st_d.phase = irqmask_pkg::PH_ACCESS;
         end
      endcase

      if (finish && PWRITE) begin
         img = merge_lanes(16'h0000, PWDATA, PSTRB);
         case (idx)
            irqmask_pkg::IDX_HI_MASK: begin
               img = merge_lanes({4'h0, st_q.hi_mask}, PWDATA, PSTRB);
               st_d.hi_mask = img[irqmask_pkg::STAGES-1:0];
            end
            irqmask_pkg::IDX_DONE_MASK: begin
               img = merge_lanes({3'h0, st_q.done_mask}, PWDATA, PSTRB);
               st_d.done_mask = img[irqmask_pkg::DONE_W-1:0];
            end
            irqmask_pkg::IDX_GPIO_CFG: begin
               img = merge_lanes({st_q.trig, 14'h0000}, PWDATA, PSTRB);
               st_d.trig = irqmask_pkg::trig_t'(img[irqmask_pkg::TRIG_LSB+:2]);
            end
            default: begin
               img = 16'h0000;
            end
         endcase
      end

      // Only the bits that were actually reported are cleared, so an event
      // that lands between the data capture and the read's end survives.
      if (finish && !PWRITE) begin
         if (idx == irqmask_pkg::IDX_HI_STAT) begin
            hi_clear = st_q.rdata[irqmask_pkg::STAGES-1:0];
         end
         if (idx == irqmask_pkg::IDX_DONE_STAT) begin
            done_clear = st_q.rdata[irqmask_pkg::DONE_W-1:0];
         end
      end

      case (st_q.trig)
         irqmask_pkg::TRIG_LOW_LEVEL:  gpio_event = !GPIO_IN;
         irqmask_pkg::TRIG_RISE_EDGE:  gpio_event = GPIO_IN && !st_q.gpio_prev;
         irqmask_pkg::TRIG_FALL_EDGE:  gpio_event = !GPIO_IN && st_q.gpio_prev;
         irqmask_pkg::TRIG_HIGH_LEVEL: gpio_event = GPIO_IN;
         default:                      gpio_event = 1'b0;
      endcase
      st_d.gpio_prev = GPIO_IN;

      st_d.hi_stat = (st_q.hi_stat & ~hi_clear) | STAGE_HIGH_EXCEEDED;
      st_d.done_stat = (st_q.done_stat & ~done_clear) |
                       {gpio_event, STAGE_DONE};

      // level interrupt from enabled pending sources
      st_d.int_n = !(|(st_d.hi_stat & st_d.hi_mask) || |(st_d.done_stat & st_d.done_mask));
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         st_q.phase     <= irqmask_pkg::PH_ACCESS;
         st_q.hi_mask   <= irqmask_pkg::HI_MASK_RESET;
         st_q.done_mask <= irqmask_pkg::DONE_MASK_RESET;
         st_q.hi_stat   <= irqmask_pkg::HI_STAT_RESET;
         st_q.done_stat <= irqmask_pkg::DONE_STAT_RESET;
         st_q.trig      <= irqmask_pkg::TRIG_RESET;
         st_q.gpio_prev <= 1'b0;
         st_q.rdata     <= 32'h0000_0000;
         st_q.slverr    <= 1'b0;
         st_q.int_n     <= 1'b1;
      end else if (CE) begin
         st_q <= st_d;
      end
   end

   // Helper signals read only by the checks below.
   logic                           wr_done;
   logic [irqmask_pkg::DONE_W-1:0] pw_lo;
   logic [irqmask_pkg::DONE_W-1:0] pending;

   assign wr_done = CE && finish && PWRITE && (PSTRB[1:0] == 2'h3);
   assign pw_lo   = PWDATA[irqmask_pkg::DONE_W-1:0];
   assign pending = {1'b0, st_q.hi_stat & st_q.hi_mask} | (st_q.done_stat & st_q.done_mask);

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   mask_reset_a : assert property (
      $past(!RESET_N) |-> (st_q.hi_mask == '0) && (st_q.done_mask == '0) && INT_N)
      else $error("Masks or interrupt not at reset value after reset.");

   hi_write_a : assert property (
      wr_done && (idx == irqmask_pkg::IDX_HI_MASK)
      |=> st_q.hi_mask == $past(pw_lo[irqmask_pkg::STAGES-1:0]))
      else $error("High mask did not take the written value.");

   done_write_a : assert property (
      wr_done && (idx == irqmask_pkg::IDX_DONE_MASK) |=> st_q.done_mask == $past(pw_lo))
      else $error("Done mask did not take the written value.");

   hi_irq_a : assert property (
      CE && |(STAGE_HIGH_EXCEEDED & st_q.hi_mask) && !(finish && PWRITE) |=> !INT_N)
      else $error("Enabled high threshold did not raise the interrupt.");

   masked_quiet_a : assert property (
      (st_q.hi_mask == '0) && (st_q.done_mask == '0) |-> INT_N)
      else $error("Interrupt asserted with every source disabled.");

   done_irq_a : assert property (
      CE && |(STAGE_DONE & st_q.done_mask[irqmask_pkg::STAGES-1:0]) && !(finish && PWRITE)
      |=> !INT_N)
      else $error("Enabled conversion completion did not raise the interrupt.");

   gpio_gate_a : assert property (
      st_q.done_stat[irqmask_pkg::GPIO_EVENT_BIT] && !st_q.done_mask[irqmask_pkg::GPIO_EVENT_BIT]
      && (st_q.hi_mask == '0) && (st_q.done_mask[irqmask_pkg::STAGES-1:0] == '0) |-> INT_N)
      else $error("Disabled input event pulled the interrupt low.");

   hi_hold_a : assert property (
      CE && |STAGE_HIGH_EXCEEDED |=> (st_q.hi_stat & $past(STAGE_HIGH_EXCEEDED))
      == $past(STAGE_HIGH_EXCEEDED))
      else $error("High status lost while the limit was exceeded.");

   rise_edge_a : assert property (
      CE && (st_q.trig == irqmask_pkg::TRIG_RISE_EDGE) && !st_q.gpio_prev && GPIO_IN
      |=> st_q.done_stat[irqmask_pkg::GPIO_EVENT_BIT])
      else $error("Rising input edge did not set the input event.");

   irq_level_a : assert property (
      INT_N == !(|pending))
      else $error("Interrupt level disagrees with pending enabled sources.");

   read_wait_a : assert property (
      CE && req && (st_q.phase == irqmask_pkg::PH_ACCESS) |=> PREADY ##1 !PREADY)
      else $error("Bus answer not given after exactly one wait state.");

   ready_pulse_a : assert property (
      CE && PREADY |=> !PREADY)
      else $error("Bus answer stood for more than one enabled cycle.");

   unmapped_err_a : assert property (
      CE && req && (st_q.phase == irqmask_pkg::PH_ACCESS) && !mapped
      |=> PSLVERR && (PRDATA == 32'h0000_0000))
      else $error("Unmapped access did not answer with an error and zero data.");

   mapped_ok_a : assert property (
      CE && req && (st_q.phase == irqmask_pkg::PH_ACCESS) && mapped |=> !PSLVERR)
      else $error("Mapped access answered with an error.");

   upper_zero_a : assert property (
      PREADY |-> (PRDATA[31:16] == 16'h0000))
      else $error("Read data carries bits above the register width.");

   reset_stat_a : assert property (
      $past(!RESET_N) |-> (st_q.hi_stat == '0) && (st_q.done_stat == '0) && !PREADY)
      else $error("Status or bus answer not cleared by reset.");

   hi_stable_a : assert property (
      !(finish && PWRITE) |=> st_q.hi_mask == $past(st_q.hi_mask))
      else $error("High mask changed without a write.");

   done_stable_a : assert property (
      !(finish && PWRITE) |=> st_q.done_mask == $past(st_q.done_mask))
      else $error("Done mask changed without a write.");

   done_hold_a : assert property (
      CE && |STAGE_DONE |=> (st_q.done_stat[irqmask_pkg::STAGES-1:0] & $past(STAGE_DONE))
      == $past(STAGE_DONE))
      else $error("Conversion completion did not set its status bit.");

   done_clear_a : assert property (
      CE && finish && !PWRITE && (idx == irqmask_pkg::IDX_DONE_STAT) && !(|STAGE_DONE)
      && !gpio_event |=> (st_q.done_stat & $past(st_q.rdata[irqmask_pkg::DONE_W-1:0])) == '0)
      else $error("Reported done status not cleared by the read.");

   hi_clear_a : assert property (
      CE && finish && !PWRITE && (idx == irqmask_pkg::IDX_HI_STAT) && !(|STAGE_HIGH_EXCEEDED)
      |=> (st_q.hi_stat & $past(st_q.rdata[irqmask_pkg::STAGES-1:0])) == '0)
      else $error("Reported high status not cleared by the read.");

   stat_readonly_a : assert property (
      CE && finish && PWRITE && (idx == irqmask_pkg::IDX_HI_STAT) && !(|STAGE_HIGH_EXCEEDED)
      |=> st_q.hi_stat == $past(st_q.hi_stat))
      else $error("Write changed the read-only high status.");

   fall_edge_a : assert property (
      CE && (st_q.trig == irqmask_pkg::TRIG_FALL_EDGE) && st_q.gpio_prev && !GPIO_IN
      |=> st_q.done_stat[irqmask_pkg::GPIO_EVENT_BIT])
      else $error("Falling input edge did not set the input event.");

   low_level_a : assert property (
      CE && (st_q.trig == irqmask_pkg::TRIG_LOW_LEVEL) && !GPIO_IN
      |=> st_q.done_stat[irqmask_pkg::GPIO_EVENT_BIT])
      else $error("Low input level did not set the input event.");

   high_level_a : assert property (
      CE && (st_q.trig == irqmask_pkg::TRIG_HIGH_LEVEL) && GPIO_IN
      |=> st_q.done_stat[irqmask_pkg::GPIO_EVENT_BIT])
      else $error("High input level did not set the input event.");

   trig_write_a : assert property (
      wr_done && (idx == irqmask_pkg::IDX_GPIO_CFG)
      |=> st_q.trig == $past(PWDATA[irqmask_pkg::TRIG_LSB+:2]))
      else $error("Trigger code did not take the written value.");

   gpio_irq_a : assert property (
      CE && st_q.done_mask[irqmask_pkg::GPIO_EVENT_BIT] && gpio_event && !(finish && PWRITE)
      |=> !INT_N)
      else $error("Enabled input event did not raise the interrupt.");

   // A stalled clock enable must hold every flop, the bus handshake included.
   ce_freeze_a : assert property (
      !CE |=> st_q == $past(st_q))
      else $error("State changed while the clock enable was low.");

   hi_irq_c   : cover property (!INT_N && |(st_q.hi_stat & st_q.hi_mask));
   done_irq_c : cover property (!INT_N && |(st_q.done_stat[irqmask_pkg::STAGES-1:0]));
   gpio_irq_c : cover property (!INT_N && st_q.done_stat[irqmask_pkg::GPIO_EVENT_BIT]);
   clear_c    : cover property (!INT_N ##[1:20] INT_N);
   freeze_c   : cover property (!CE ##1 CE);

endmodule : stage_irq_masks

/* apb_host.sv */
// Host processor model that drives APB transfers into the stage interrupt mask block.
`timescale 1ns/1ps
module apb_host (
   input  wire logic        clk,
   output logic             psel    = 1'b0,
   output logic             penable = 1'b0,
   output logic             pwrite  = 1'b0,
   output logic [11:0]      paddr   = 12'h000,
   output logic [31:0]      pwdata  = 32'h00000000,
   output logic [3:0]       pstrb   = 4'h0,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
      logic [31:0] wd;
      wd = wdata;
      if (addr == 12'h018) begin
         wd[31:12] = 20'h00000;
      end else if (addr == 12'h01C) begin
         wd[31:13] = 19'h00000;
      end
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      pstrb   <= 4'h3;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released data lines must not keep showing the last word.
      pwdata  <= ~wd;
   endtask : xfer
endmodule : apb_host

/* stage_irq_masks_test.sv */
// Self-checking testbench of the stage interrupt mask block.
`timescale 1ns/1ps
module stage_irq_masks_test;
   logic        clk, reset_n, ce, psel, penable, pwrite, gpio_in, int_n, pready, pslverr, rerr;
   logic [11:0] paddr, hi_exc, done_pl;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  pstrb;
   int          n_fail = 0;
   int          total_checks = 0;
   int          cycles = 0;

   stage_irq_masks u_stage_irq_masks (.CLK(clk), .RESET_N(reset_n), .CE(ce), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STAGE_HIGH_EXCEEDED(hi_exc),
      .STAGE_DONE(done_pl), .GPIO_IN(gpio_in), .INT_N(int_n));
   apb_host u_apb_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   // The whole run needs about two hundred cycles; a hang is cut well after that.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_apb_host.xfer(1'b1, a, d, rdat, rerr);
      chk({31'h0, rerr}, 32'h0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      u_apb_host.xfer(1'b0, a, 32'h0, rdat, rerr);
      chk(rdat, exp);
      chk({31'h0, rerr}, {31'h0, exp_err});
   endtask : rd

   task automatic ck_int(input logic exp);
      @(negedge clk);
      chk({31'h0, int_n}, {31'h0, exp});
   endtask : ck_int

   task automatic pulse_done(input int b);
      @(posedge clk);
      done_pl[b] <= 1'b1;
      @(posedge clk);
      done_pl <= 12'h000;
   endtask : pulse_done

   initial begin
      ce = 1'b1;
      reset_n = 1'b0;
      hi_exc = 12'h000;
      done_pl = 12'h000;
      gpio_in = 1'b1;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd(12'h018, 32'h0, 1'b0);
      rd(12'h01C, 32'h0, 1'b0);
      ck_int(1'b1);
      wr(12'h018, 32'h00000FFF);
      rd(12'h018, 32'h00000FFF, 1'b0);
      wr(12'h01C, 32'h00001FFF);
      rd(12'h01C, 32'h00001FFF, 1'b0);
      rd(12'h03C, 32'h0, 1'b1);
      wr(12'h024, 32'h00000FFF);
      rd(12'h024, 32'h0, 1'b0);
      $display("test registers done");
      wr(12'h018, 32'h0);
      wr(12'h01C, 32'h0);
      pulse_done(3);
      hi_exc <= 12'h020;
      ck_int(1'b1);
      rd(12'h028, 32'h00000008, 1'b0);
      rd(12'h024, 32'h00000020, 1'b0);
      hi_exc <= 12'h000;
      rd(12'h024, 32'h00000020, 1'b0);
      rd(12'h024, 32'h0, 1'b0);
      $display("test disabled sources done");
      wr(12'h01C, 32'h00000008);
      pulse_done(3);
      ck_int(1'b0);
      rd(12'h028, 32'h00000008, 1'b0);
      @(posedge clk);
      ck_int(1'b1);
      pulse_done(3);
      ck_int(1'b0);
      wr(12'h01C, 32'h0);
      @(posedge clk);
      ck_int(1'b1);
      rd(12'h028, 32'h00000008, 1'b0);
      wr(12'h018, 32'h00000020);
      hi_exc <= 12'h020;
      @(posedge clk);
      ck_int(1'b0);
      @(posedge clk);
      hi_exc <= 12'h000;
      rd(12'h024, 32'h00000020, 1'b0);
      @(posedge clk);
      ck_int(1'b1);
      $display("test enabled sources done");
      // A completion pulse seen only while the enable is low must be lost.
      wr(12'h01C, 32'h00000008);
      ce      <= 1'b0;
      done_pl <= 12'h008;
      repeat (2) @(posedge clk);
      done_pl <= 12'h000;
      ce      <= 1'b1;
      ck_int(1'b1);
      rd(12'h028, 32'h0, 1'b0);
      $display("test clock enable done");
      wr(12'h01C, 32'h00001000);
      for (int c = 0; c < 4; c++) begin
         gpio_in <= ~c[0];
         wr(12'h030, {16'h0000, c[1:0], 14'h0000});
         u_apb_host.xfer(1'b0, 12'h028, 32'h0, rdat, rerr);
         rd(12'h028, 32'h0, 1'b0);
         gpio_in <= c[0];
         @(posedge clk);
         ck_int(1'b0);
         rd(12'h028, 32'h00001000, 1'b0);
      end
      $display("test input triggers done");
      close_out();
   end
endmodule : stage_irq_masks_test
